// ===== hw/bcs_regs.sv
// Board control and status register file: configuration word, board
// control word and module presence status, plus hard-reset config drive.
// Assumes a host bus with chip select, write enable and a shared data bus
// whose level the surroundings resolve from data_out and data_oe.
//
// What this block does
// - Configuration word at offset zero, readable and writable except during hard reset.
// - Board control word at offset four, read/write, defaults at power-on.
// - Status word at offset eight is read only; writes ignored.
// - During hard reset with flash-config disabled, drive config word.
// - Config written now only reaches the processor at next hard reset.
// - Control bit 4 low stops config drive; flash supplies it; default 1.
// - Reserved config bits 2, 6, 15 stored and driven like others.
// - Config bits 0, 1, 3 arbitration, prefix, boot disable; 0, 1, 0.
// - Config bits 4-5 boot port size, default 00.
// - Config bits 7-8 initial map base, default 10.
// - Config bits 9-10 second card channel pin function, default 00.
// - Config bits 11-12 debug port location, default 00.
// - Config bits 13-14 bus clock divide factor, default 00.
// - Control bit 0 low maps flash in; default 0.
// - Control bit 1 low maps DRAM in; default 0.
// - Control bits 7, 13 low enable serial transceivers; default 1.
// - Control bit 8 low enables card socket buffers; default 1.
// - Control bits 9, 15 select card supply voltage; defaults 0, 1.
// - Control bits 10-11 select card programming voltage; default 11.
// - Control bit 12 low requests 16-bit DRAM; default 1.
// - Control bit 14 high enables SDRAM, low puts it in low power.
// - Status bits 0-3 flash detect, 5-8 DRAM detect, from socket.
// - Registers repeat throughout the whole chip-select region.
`timescale 1ns/1ps
module bcs_regs
	import bcs_pkg::*;
#(
	parameter int unsigned ADDR_W = BCS_ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              bus_cs_n,
	input  wire logic              bus_we_n,
	input  wire logic [ADDR_W-1:0] bus_addr,
	input  wire logic [31:0]       data_in,
	output logic      [31:0]       data_out,
	output logic                   data_oe,
	input  wire logic              hard_reset_n,
	input  wire logic [3:0]        flash_type_detect,
	input  wire logic [3:0]        dram_size_delay_detect,
	output logic                   flash_enable_n,
	output logic                   dram_enable_n,
	output logic                   flash_config_enable_n,
	output logic                   serial_xcvr1_enable_n,
	output logic                   serial_xcvr2_enable_n,
	output logic                   card_socket_enable_n,
	output logic                   card_supply_sel_lo,
	output logic                   card_supply_sel_hi,
	output logic      [1:0]        card_prog_voltage_sel,
	output logic                   dram_half_word_n,
	output logic                   sync_dram_enable
);

	// ************************************************************
	// Pin synchronisation
	// ************************************************************
	bcs_pins_type pins_raw;
	bcs_pins_type pins_s;

	assign pins_raw.cs       = !bus_cs_n;
	assign pins_raw.we       = !bus_we_n;
	assign pins_raw.hreset   = !hard_reset_n;
	assign pins_raw.addr     = 15'(bus_addr);
	assign pins_raw.wdata    = data_in;
	assign pins_raw.flash_pd = flash_type_detect;
	assign pins_raw.dram_pd  = dram_size_delay_detect;

	// Address and data are assumed stable while select is held, so the
	// per-bit synchronisers cannot tear a word once select is seen.
	bcs_sync #(
		.WIDTH ($bits(bcs_pins_type)),
		.INIT  ('0)
	) u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      (pins_raw),
		.q      (pins_s)
	);

	// ************************************************************
	// State
	// ************************************************************
	logic [31:0] cfg_q;
	logic [31:0] cfg_d;
	logic [31:0] ctl_q;
	logic [31:0] ctl_d;
	logic [31:0] snap_q;
	logic [31:0] snap_d;
	logic [31:0] dout_q;
	logic [31:0] dout_d;
	logic        oe_q;
	logic        oe_d;
	logic        cs_q;
	logic        hr_q;

	// ************************************************************
	// Decode
	// ************************************************************
	wire [2:0]  idx      = pins_s.addr[BCS_IDX_LSB +: BCS_IDX_W];
	wire        cs_rise  = pins_s.cs && !cs_q;
	wire        hr_rise  = pins_s.hreset && !hr_q;
	wire        wr_ev    = cs_rise && pins_s.we && !pins_s.hreset;
	wire        rd_act   = pins_s.cs && !pins_s.we && !pins_s.hreset;
	wire        hit_cfg  = idx == BCS_IDX_CFG;
	wire        hit_ctl  = idx == BCS_IDX_CTL;
	wire        hit_stat = idx == BCS_IDX_STAT;
	wire        drive_en = pins_s.hreset && ctl_q[BCS_CTL_FCFG];

	wire [31:0] stat_w   = {23'h0,
		pins_s.dram_pd, 1'b0, pins_s.flash_pd};

	// Index three upward and status holes read as zero.
	wire [31:0] rd_mux   = hit_cfg  ? cfg_q :
	                       hit_ctl  ? ctl_q :
	                       hit_stat ? stat_w : 32'h0;

	// ************************************************************
	// Next-state
	// ************************************************************
	assign cfg_d = (wr_ev && hit_cfg) ?
		(pins_s.wdata & BCS_CFG_MASK) : cfg_q;
	assign ctl_d = (wr_ev && hit_ctl) ?
		(pins_s.wdata & BCS_CTL_MASK) : ctl_q;
	// Status offset has no storage, so a write there changes nothing.

	// Snapshot taken on entry to hard reset; later writes wait for the
	// next hard reset before the processor sees them.
	assign snap_d = hr_rise ? cfg_q : snap_q;

	// Hard-reset drive takes priority; reads are refused during it.
	assign oe_d   = drive_en || rd_act;
	assign dout_d = drive_en ? (hr_rise ? cfg_q : snap_q) :
	                rd_act   ? rd_mux : 32'h0;

	// ************************************************************
	// Registers
	// ************************************************************
	// Power-on values:
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_q <= BCS_CFG_RESET;
			ctl_q <= BCS_CTL_RESET;
		end else begin
			cfg_q <= cfg_d;
			ctl_q <= ctl_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			snap_q <= BCS_CFG_RESET;
			cs_q   <= 1'b0;
			hr_q   <= 1'b0;
		end else begin
			snap_q <= snap_d;
			cs_q   <= pins_s.cs;
			hr_q   <= pins_s.hreset;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dout_q <= 32'h0;
			oe_q   <= 1'b0;
		end else begin
			dout_q <= dout_d;
			oe_q   <= oe_d;
		end
	end

	// ************************************************************
	// Outputs, all straight from flops
	// ************************************************************
	assign data_out              = dout_q;
	assign data_oe               = oe_q;
	assign flash_enable_n        = ctl_q[BCS_CTL_FLASH_N];
	assign dram_enable_n         = ctl_q[BCS_CTL_DRAM_N];
	assign flash_config_enable_n = ctl_q[BCS_CTL_FCFG];
	assign serial_xcvr1_enable_n = ctl_q[BCS_CTL_SER1_N];
	assign serial_xcvr2_enable_n = ctl_q[BCS_CTL_SER2_N];
	assign card_socket_enable_n  = ctl_q[BCS_CTL_CARD_N];
	assign card_supply_sel_lo    = ctl_q[BCS_CTL_VCC_LO];
	assign card_supply_sel_hi    = ctl_q[BCS_CTL_VCC_HI];
	assign card_prog_voltage_sel =
		ctl_q[BCS_CTL_VPP_LO +: 2];
	assign dram_half_word_n      = ctl_q[BCS_CTL_HALF_N];
	assign sync_dram_enable      = ctl_q[BCS_CTL_SDRAM];

	// ************************************************************
	// Checks
	// ************************************************************
	cfg_write_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_ev && hit_cfg) |=>
			cfg_q == ($past(pins_s.wdata) & BCS_CFG_MASK))
		else $error("config write not stored");

	ctl_write_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_ev && hit_ctl) |=>
			ctl_q == ($past(pins_s.wdata) & BCS_CTL_MASK))
		else $error("control write not stored");

	stat_ro_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_ev && hit_stat) |=> $stable(cfg_q) && $stable(ctl_q))
		else $error("status write changed a register");

	hr_drive_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(pins_s.hreset && hr_q && ctl_q[BCS_CTL_FCFG]) |=>
			oe_q && dout_q == $past(snap_q))
		else $error("config word not driven in hard reset");

	hr_snap_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(pins_s.hreset && hr_q) |=> $stable(snap_q) || !hr_q)
		else $error("driven config changed inside hard reset");

	hr_quiet_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(pins_s.hreset && !ctl_q[BCS_CTL_FCFG]) |=> !oe_q)
		else $error("config driven while flash supplies it");

	stat_read_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(rd_act && hit_stat) |=>
			oe_q && dout_q == {23'h0, $past(pins_s.dram_pd),
				1'b0, $past(pins_s.flash_pd)})
		else $error("status read wrong");

	unimpl_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		((cfg_q & ~BCS_CFG_MASK) == 32'h0) &&
		((ctl_q & ~BCS_CTL_MASK) == 32'h0))
		else $error("unimplemented bit set");

	mirror_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(rd_act && hit_ctl && pins_s.addr[14:5] != 10'h0) |=>
			dout_q == $past(ctl_q))
		else $error("register image not repeated");

	cfg_read_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(rd_act && hit_cfg) |=> oe_q && dout_q == $past(cfg_q))
		else $error("config read wrong");

	ctl_read_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(rd_act && hit_ctl) |=> oe_q && dout_q == $past(ctl_q))
		else $error("control read wrong");

	cfg_hold_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		!(wr_ev && hit_cfg) |=> $stable(cfg_q))
		else $error("config changed without a write");

	ctl_hold_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		!(wr_ev && hit_ctl) |=> $stable(ctl_q))
		else $error("control changed without a write");

	// Refused writes keep the word the processor will see.
	hr_refuse_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		pins_s.hreset |=> $stable(cfg_q) && $stable(ctl_q))
		else $error("register written during hard reset");

	snap_load_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		hr_rise |=> snap_q == $past(cfg_q))
		else $error("snapshot not taken on hard reset entry");

	hr_entry_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(hr_rise && ctl_q[BCS_CTL_FCFG]) |=>
			oe_q && dout_q == $past(cfg_q))
		else $error("config word not driven on hard reset entry");

	// Bus released when idle; another driver may own it then.
	bus_quiet_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(!pins_s.cs && !pins_s.hreset) |=>
			!oe_q && dout_q == 32'h0)
		else $error("data bus driven while idle");

	hole_read_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(rd_act && !hit_cfg && !hit_ctl && !hit_stat) |=>
			oe_q && dout_q == 32'h0)
		else $error("unused register image not zero");

endmodule

// ===== hw/bcs_pkg.sv
// Constants and types shared by the board control and status register file.
// Assumes a host local bus chip-select region that decodes to this block.
package bcs_pkg;

	// ************************************************************
	// Bus geometry
	// ************************************************************
	localparam int unsigned BCS_ADDR_W   = 15;
	localparam int unsigned BCS_DATA_W   = 32;
	localparam int unsigned BCS_IDX_LSB  = 2;
	localparam int unsigned BCS_IDX_W    = 3;

	// ************************************************************
	// Register offsets, as word indexes within one 32-byte image
	// ************************************************************
	localparam logic [2:0] BCS_IDX_CFG  = 3'h0;
	localparam logic [2:0] BCS_IDX_CTL  = 3'h1;
	localparam logic [2:0] BCS_IDX_STAT = 3'h2;

	// ************************************************************
	// Implemented bits and power-on values
	// ************************************************************
	localparam logic [31:0] BCS_CFG_MASK  = 32'h0000_ffff;
	localparam logic [31:0] BCS_CFG_RESET = 32'h0000_0102;
	localparam logic [31:0] BCS_CTL_MASK  = 32'h0000_ff93;
	localparam logic [31:0] BCS_CTL_RESET = 32'h0000_fd90;

	// ************************************************************
	// Configuration word field positions
	// ************************************************************
	localparam int unsigned BCS_CFG_ARB     = 0;
	localparam int unsigned BCS_CFG_IPFX    = 1;
	localparam int unsigned BCS_CFG_BOOT_DISABLE    = 3;
	localparam int unsigned BCS_CFG_BPS_LO  = 4;
	localparam int unsigned BCS_CFG_ISB_LO  = 7;
	localparam int unsigned BCS_CFG_DBG_LO  = 9;
	localparam int unsigned BCS_CFG_DBP_LO  = 11;
	localparam int unsigned BCS_CFG_BDF_LO  = 13;

	// ************************************************************
	// Board control word field positions
	// ************************************************************
	localparam int unsigned BCS_CTL_FLASH_N = 0;
	localparam int unsigned BCS_CTL_DRAM_N  = 1;
	localparam int unsigned BCS_CTL_FCFG    = 4;
	localparam int unsigned BCS_CTL_SER1_N  = 7;
	localparam int unsigned BCS_CTL_CARD_N  = 8;
	localparam int unsigned BCS_CTL_VCC_LO  = 9;
	localparam int unsigned BCS_CTL_VPP_LO  = 10;
	localparam int unsigned BCS_CTL_HALF_N  = 12;
	localparam int unsigned BCS_CTL_SER2_N  = 13;
	localparam int unsigned BCS_CTL_SDRAM   = 14;
	localparam int unsigned BCS_CTL_VCC_HI  = 15;

	// ************************************************************
	// Status word field positions
	// ************************************************************
	localparam int unsigned BCS_ST_FLASH_LO = 0;
	localparam int unsigned BCS_ST_DRAM_LO  = 5;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic                  cs;
		logic                  we;
		logic                  hreset;
		logic [14:0]           addr;
		logic [31:0]           wdata;
		logic [3:0]            flash_pd;
		logic [3:0]            dram_pd;
	} bcs_pins_type;

endpackage

// ===== hw/bcs_sync.sv
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes the bundle is a plain bit vector; only the second stage is read.
`timescale 1ns/1ps
module bcs_sync #(
	parameter int unsigned WIDTH = 8,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	// ************************************************************
	// Two flops, the first read only by the second
	// ************************************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= INIT;
			q      <= INIT;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

// ===== bench/bcs_host_model.sv
// Host local bus model: word writes and reads through one chip select.
// Assumes the block samples every pin on clk and answers by data_oe.
`timescale 1ns/1ps
module bcs_host_model (
	input  wire logic        clk,
	output logic             cs_n,
	output logic             we_n,
	output logic [14:0]      addr,
	output logic [31:0]      wdata,
	input  wire logic [31:0] rdata,
	input  wire logic        oe
);
	initial begin
		cs_n = 1'b1;
		we_n = 1'b1;
		addr = '0;
		wdata = '0;
	end

	// ************************************************************
	// Bus cycles, entered just after a rising edge
	// ************************************************************
	task automatic wr(input logic [14:0] a, input logic [31:0] d);
		cs_n  <= 1'b0;
		we_n  <= 1'b0;
		addr  <= a;
		wdata <= d;
		repeat (5) @(posedge clk);
		cs_n  <= 1'b1;
		we_n  <= 1'b1;
		// Released line shows the inverse, never a stale match
		wdata <= ~d;
		repeat (4) @(posedge clk);
	endtask

	task automatic rd(input logic [14:0] a, output logic [31:0] d);
		cs_n <= 1'b0;
		addr <= a;
		// Answer stands from the third edge while cs stays low
		repeat (5) @(posedge clk);
		d = (oe === 1'b1) ? rdata : 'x;
		cs_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ===== bench/board_control_status_regs_tb.sv
// Self-checking bench for the board control and status register file.
// Assumes the host model drives the bus and the bench drives the rest.
`timescale 1ns/1ps
module board_control_status_regs_tb;
	import bcs_pkg::*;
	logic        clk;
	logic        arst_n;
	logic        hard_reset_n;
	logic [3:0]  flash_det;
	logic [3:0]  dram_det;
	logic        cs_n;
	logic        we_n;
	logic [14:0] addr;
	logic [31:0] wdata;
	logic [31:0] data_out;
	logic        data_oe;
	wire  [15:0] pins;
	int          error_cnt;
	int          tests_run;

	bcs_host_model u_host (.clk(clk), .cs_n(cs_n), .we_n(we_n),
		.addr(addr), .wdata(wdata), .rdata(data_out), .oe(data_oe));

	bcs_regs u_dut (.clk(clk), .arst_n(arst_n), .bus_cs_n(cs_n),
		.bus_we_n(we_n), .bus_addr(addr), .data_in(wdata),
		.data_out(data_out), .data_oe(data_oe),
		.hard_reset_n(hard_reset_n), .flash_type_detect(flash_det),
		.dram_size_delay_detect(dram_det),
		.flash_enable_n(pins[0]), .dram_enable_n(pins[1]),
		.flash_config_enable_n(pins[4]),
		.serial_xcvr1_enable_n(pins[7]),
		.serial_xcvr2_enable_n(pins[13]),
		.card_socket_enable_n(pins[8]),
		.card_supply_sel_lo(pins[9]), .card_supply_sel_hi(pins[15]),
		.card_prog_voltage_sel(pins[11:10]),
		.dram_half_word_n(pins[12]), .sync_dram_enable(pins[14]));
	assign pins[3:2] = 2'h0;
	assign pins[6:5] = 2'h0;

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ************************************************************
	// Shared checks
	// ************************************************************
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rc(input logic [14:0] a, input logic [31:0] exp);
		logic [31:0] d;
		u_host.rd(a, d);
		chk({1'b0, d}, {1'b0, exp});
	endtask

	task automatic hr(input logic drv, input logic [31:0] exp);
		hard_reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk({data_oe, data_out}, drv ? {1'b1, exp} : 33'h0);
		hard_reset_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk({32'h0, data_oe}, 33'h0);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_defaults;
		chk({17'h0, pins}, 33'h0fd90);
		rc(15'h0000, 32'h0000_0102);
		rc(15'h0004, 32'h0000_fd90);
		$display("test defaults done");
	endtask

	task automatic t_rw;
		u_host.wr(15'h0000, 32'hffff_ffff);
		rc(15'h0000, 32'h0000_ffff);
		u_host.wr(15'h0004, 32'hffff_ffff);
		rc(15'h0004, 32'h0000_ff93);
		chk({17'h0, pins}, 33'h0ff93);
		u_host.wr(15'h0004, 32'h0000_0000);
		chk({17'h0, pins}, 33'h0);
		u_host.wr(15'h7fe4, 32'h0000_5a10);
		rc(15'h0004, 32'h0000_5a10);
		rc(15'h7fe4, 32'h0000_5a10);
		chk({17'h0, pins}, 33'h05a10);
		rc(15'h0008, 32'h0000_00aa);
		u_host.wr(15'h0008, 32'hffff_ffff);
		rc(15'h0028, 32'h0000_00aa);
		rc(15'h0000, 32'h0000_ffff);
		rc(15'h0004, 32'h0000_5a10);
		flash_det <= 4'h3;
		dram_det  <= 4'hc;
		repeat (4) @(posedge clk);
		rc(15'h0008, 32'h0000_0183);
		rc(15'h000c, 32'h0000_0000);
		$display("test access done");
	endtask

	task automatic t_hreset;
		u_host.wr(15'h0004, 32'h0000_fd90);
		u_host.wr(15'h0000, 32'h0000_a5c7);
		hr(1'b1, 32'h0000_a5c7);
		u_host.wr(15'h0000, 32'h0000_1234);
		chk({32'h0, data_oe}, 33'h0);
		u_host.wr(15'h0004, 32'h0000_fd80);
		hr(1'b0, 32'h0);
		u_host.wr(15'h0004, 32'h0000_fd90);
		hr(1'b1, 32'h0000_1234);
		$display("test hard reset done");
	endtask

	// ************************************************************
	// Main sequence and verdict
	// ************************************************************
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#200000;
		error_cnt++;
		print_verdict();
	end

	initial begin
		error_cnt = 0;
		tests_run = 0;
		arst_n = 1'b0;
		hard_reset_n = 1'b1;
		flash_det = 4'ha;
		dram_det = 4'h5;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_defaults();
		t_rw();
		t_hreset();
		print_verdict();
	end
endmodule
